// >>> dv/jtdr_dbg_model.sv
// Behavioural boundary-scan controller that walks the TAP and scans chains.
`timescale 1ns/1ps
`default_nettype none
module jtdr_dbg_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end

    // One 32 ns test clock period; the clock rests low between frames.
    task automatic tick(input logic m, input logic d, output logic o);
        #1;
        tms_o = m;
        tdi_o = d;
        #15;
        tck_o = 1'h1;
        o = tdo_i;
        #16;
        tck_o = 1'h0;
    endtask

    task automatic goto_tlr();
        logic o;
        for (int i = 0; i < 5; i++) begin
            tick(1'h1, 1'h1, o);
        end
    endtask

    // Starts and ends in Run-Test/Idle; the last bit leaves the shift state.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1'h1, 1'h1, o);
        if (ir) begin
            tick(1'h1, 1'h1, o);
        end
        tick(1'h0, 1'h1, o);
        tick(1'h0, 1'h1, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'h1, 1'h1, o);
        tick(1'h0, 1'h1, o);
    endtask
endmodule
`default_nettype wire

// >>> dv/jtdr_top_bench.sv
// Self-checking bench for the test port data registers.
`timescale 1ns/1ps
`default_nettype none
module jtdr_top_bench;
    localparam logic [3:0] VER = 4'h1;
    // Part and maker codes are arbitrary.
    localparam logic [15:0] PARTNO = 16'h1234;
    localparam logic [10:0] MAKER = 11'h155;
    logic clock_i = 1'h0, rst_i = 1'h1, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic pen = 1'h1, pdis = 1'h0, dbgf = 1'h0, lk1 = 1'h0, lk2 = 1'h0;
    logic req = 1'h0, erase = 1'h0, grant, ext_n = 1'h1, opt = 1'h0;
    logic core_rst, wr = 1'h0, rd = 1'h0, mapped, pe, ext, bsel, bsr = 1'h1;
    logic [7:0] wdata = 8'h00, rdata, b;
    logic [15:0] st;
    logic [31:0] d;
    wire tdo_pin;
    int mismatches = 0, n_compared = 0, cycles = 0;
    logic [13:0] rows [10] = '{14'h09FF, 14'h03FF, 14'h0C6A, 14'h286A,
        14'h2C6A, 14'h346A, 14'h386A, 14'h3C6A, 14'h206A, 14'h246A};

    assign tdo_pin = tdo_oe_o ? tdo_o : 1'h1;
    initial begin
        forever #50 clock_i = ~clock_i;
    end

    jtdr_top #(.VERSION(VER), .PART(PARTNO), .MFR(MAKER),
        .TOUT_FAST(16'h0004), .TOUT_SLOW(16'h0010)) u_jtdr_top (
        .clock_i(clock_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .test_port_enable_fuse_i(pen), .test_port_disable_bit_i(pdis),
        .debug_enable_fuse_i(dbgf), .lock_bit_one_i(lk1),
        .lock_bit_two_i(lk2), .fuse_prog_req_i(req), .chip_erase_i(erase),
        .fuse_prog_grant_o(grant), .ext_reset_n_i(ext_n), .clk_opt_i(opt),
        .core_reset_o(core_rst), .cpu_wr_i(wr), .cpu_rd_i(rd),
        .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .comm_mapped_o(mapped),
        .port_enabled_o(pe), .extest_o(ext), .bsr_sel_o(bsel),
        .tap_state_o(st), .bsr_tdo_i(bsr));
    jtdr_dbg_model u_jtdr_dbg_model (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo_pin));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic sc(input logic ir, input int n, input logic [31:0] din);
        u_jtdr_dbg_model.scan(ir, n, din, d);
    endtask

    task automatic cpu_rw(input logic w, input logic [7:0] v);
        @(negedge clock_i);
        wr = w;
        rd = ~w;
        wdata = v;
        @(negedge clock_i);
        wr = 1'h0;
        rd = 1'h0;
        b = rdata;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        logic o;
        // The test clock runs under reset so that the link side resets too.
        fork
            clk(2);
            u_jtdr_dbg_model.goto_tlr();
        join
        check("core_reset_o", core_rst, 1'h1);
        check("tdo_oe_o", tdo_oe_o, 1'h0);
        rst_i = 1'h0;
        clk(4);
        check("port_enabled_o", pe, 1'h1);
        u_jtdr_dbg_model.goto_tlr();
        check("tap_state_o", st, jtdr_pkg::ST_TLR);
        u_jtdr_dbg_model.tick(1'h0, 1'h1, o);
        sc(1'h0, 32, 32'h0);
        check("id", d, {VER, PARTNO, MAKER, 1'h1});
        $display("Reset and identification test done");
        for (int i = 0; i < 10; i++) begin
            sc(1'h1, 4, {28'h0, rows[i][13:10]});
            check("ir capture", d[3:0], 4'h1);
            check("extest_o", ext, rows[i][9]);
            check("bsr_sel_o", bsel, rows[i][8]);
            sc(1'h0, 8, 32'hB5);
            check("dr out", d[7:0], rows[i][7:0]);
        end
        $display("Opcode table test done");
        clk(1);
        opt = 1'h1;
        sc(1'h1, 4, 32'hC);
        sc(1'h0, 1, 32'h1);
        clk(20);
        check("core_reset_o", core_rst, 1'h1);
        check("tap_state_o", st, jtdr_pkg::ST_RTI);
        sc(1'h0, 1, 32'h0);
        clk(3);
        check("core_reset_o", core_rst, 1'h1);
        clk(30);
        check("core_reset_o", core_rst, 1'h0);
        ext_n = 1'h0;
        opt = 1'h0;
        clk(4);
        check("core_reset_o", core_rst, 1'h1);
        ext_n = 1'h1;
        clk(6);
        check("core_reset_o", core_rst, 1'h1);
        clk(1);
        check("core_reset_o", core_rst, 1'h0);
        clk(33);
        $display("Device reset test done");
        dbgf = 1'h1;
        cpu_rw(1'h1, 8'hFF);
        cpu_rw(1'h0, 8'h00);
        check("unmapped read", {mapped, b}, 9'h000);
        sc(1'h1, 4, 32'h9);
        sc(1'h0, 9, 32'h1);
        check("acc capture", d[8:0], 9'h000);
        clk(4);
        check("comm_mapped_o", mapped, 1'h1);
        cpu_rw(1'h1, 8'h3C);
        cpu_rw(1'h0, 8'h00);
        check("cpu read dirty", b, 8'hBC);
        sc(1'h1, 4, 32'h8);
        sc(1'h0, 9, 32'h0);
        check("debug capture", d[8:0], 9'h13C);
        clk(4);
        cpu_rw(1'h0, 8'h00);
        check("cpu read clean", b, 8'h3C);
        $display("Debug byte test done");
        req = 1'h1;
        clk(2);
        check("grant open", grant, 1'h1);
        lk2 = 1'h1;
        clk(2);
        check("grant locked", grant, 1'h0);
        erase = 1'h1;
        clk(1);
        erase = 1'h0;
        clk(2);
        check("grant erased", grant, 1'h1);
        pdis = 1'h1;
        clk(4);
        check("port_enabled_o", pe, 1'h0);
        u_jtdr_dbg_model.goto_tlr();
        u_jtdr_dbg_model.tick(1'h0, 1'h1, o);
        check("held tap_state_o", st, jtdr_pkg::ST_TLR);
        $display("Fuse guard and port disable test done");
        clk(1);
        rst_i = 1'h1;
        pdis = 1'h0;
        fork
            clk(2);
            u_jtdr_dbg_model.goto_tlr();
        join
        rst_i = 1'h0;
        clk(4);
        check("core_reset_o", core_rst, 1'h0);
        check("comm_mapped_o", mapped, 1'h0);
        u_jtdr_dbg_model.goto_tlr();
        u_jtdr_dbg_model.tick(1'h0, 1'h1, o);
        sc(1'h0, 32, 32'h0);
        check("id after reset", d, {VER, PARTNO, MAKER, 1'h1});
        $display("Mid-run reset test done");
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> rtl/jtdr_defines.svh
// Constants of the test port data registers and instruction decode.
// What this block does
// R1: Decode private debug opcodes 8 to B; only 8 and 9 are decoded.
// R2: Port works only with fuse set, bit clear.
// R3: Programming needs only the four test pins.
// R4: Locked part refuses debug fuse until erase.
// R5: CPU write stores byte and sets dirty.
// R6: CPU read gives seven bits plus dirty.
// R7: Debugger clears dirty after reading byte.
// R8: Comm byte mapped only with fuse and enable.
// R9: Identification instruction selected after reset.
// R10: Entering reset floats every port pin.
// R11: External test drives boundary latches immediately.
// R12: Controller preloads safe values before external test.
// R13: Scan works with chip clock fast or stopped.
// R14: Bypass is one stage, zero at capture.
// R15: Version field is four bits, revision based.
// R16: Part number field is sixteen bits.
// R17: Manufacturer field is eleven bits.
// R18: Reset bit one holds device in reset.
// R19: Release adds fuse selected reset time-out.
// R20: Reset bit acts unlatched, while shifting.
// R21: Reset from pin or reset instruction.
// R22: Boundary chain drives and observes pins.
// R23: Four-bit instruction codes 0,1,2,C,F.
// R24: All shift registers move LSB first.
// R25: Reset instruction leaves the TAP alone.
// R26: Five TMS highs reach test-logic-reset.
// R27: Identification layout version, part, maker, one.
// R28: Latched instruction selects data path, default bypass.
`ifndef JTDR_DEFINES_SVH
`define JTDR_DEFINES_SVH

`define JTDR_IR_W 4
`define JTDR_IR_EXTEST 4'h0
`define JTDR_IR_IDCODE 4'h1
`define JTDR_IR_SAMPLE 4'h2
`define JTDR_IR_DBG_A 4'h8
`define JTDR_IR_DBG_B 4'h9
`define JTDR_IR_DBG_C 4'hA
`define JTDR_IR_DBG_D 4'hB
`define JTDR_IR_DEVRST 4'hC
`define JTDR_IR_BYPASS 4'hF
`define JTDR_IR_CAPTURE 4'h1

`define JTDR_ID_W 32
`define JTDR_ID_VER_LSB 28
`define JTDR_ID_PART_LSB 12
`define JTDR_ID_MFR_LSB 1
// The version, part and maker values below are arbitrary.
`define JTDR_ID_VERSION 4'h0
`define JTDR_ID_PART 16'h5A5A
`define JTDR_ID_MFR 11'h2AA

`define JTDR_DBG_W 9
`define JTDR_TOUT_W 16
`define JTDR_TOUT_FAST 16'h0010
`define JTDR_TOUT_SLOW 16'h1000

`endif

// >>> rtl/jtdr_pkg.sv
// Types shared by the test port data register block.
package jtdr_pkg;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PSDR = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PSIR = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR = 16'h8000
    } jtdr_tap_t;

endpackage

// >>> rtl/jtdr_shreg.sv
// Capture and shift register, shifting toward bit zero.
`timescale 1ns/1ps
`default_nettype none
module jtdr_shreg #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic [W-1:0] cap_val_i,
    input wire logic sin_i,
    output logic [W-1:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else if (capture_i) begin
            q_o <= cap_val_i;
        end else if (shift_i) begin
            q_o <= {sin_i, q_o[W-1:1]}; // R24
        end
    end
endmodule
`default_nettype wire

// >>> rtl/jtdr_sync.sv
// Two-flop level synchroniser, one per bit.
`timescale 1ns/1ps
`default_nettype none
module jtdr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/jtdr_top.sv
// Test port controller, data registers and debug byte channel.
`timescale 1ns/1ps
`default_nettype none
`include "jtdr_defines.svh"
module jtdr_top #(
    parameter logic [3:0] VERSION = `JTDR_ID_VERSION,
    parameter logic [15:0] PART = `JTDR_ID_PART,
    parameter logic [10:0] MFR = `JTDR_ID_MFR,
    parameter logic [`JTDR_TOUT_W-1:0] TOUT_FAST = `JTDR_TOUT_FAST,
    parameter logic [`JTDR_TOUT_W-1:0] TOUT_SLOW = `JTDR_TOUT_SLOW
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic test_port_enable_fuse_i,
    input wire logic test_port_disable_bit_i,
    input wire logic debug_enable_fuse_i,
    input wire logic lock_bit_one_i,
    input wire logic lock_bit_two_i,
    input wire logic fuse_prog_req_i,
    input wire logic chip_erase_i,
    output logic fuse_prog_grant_o,
    input wire logic ext_reset_n_i,
    input wire logic clk_opt_i,
    output logic core_reset_o,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    output logic comm_mapped_o,
    output logic port_enabled_o,
    output logic extest_o,
    output logic bsr_sel_o,
    output logic [15:0] tap_state_o,
    input wire logic bsr_tdo_i
);

    ////////////////////////////////////////////////////////////////////////
    // Core clock side: enables, fuse guard, debug byte, device reset.

    logic port_en;
    logic dbg_ok;
    logic tap_hold;
    logic erased;
    logic [7:0] comm_byte;
    logic dirty;
    logic clr_seen;
    logic [`JTDR_TOUT_W-1:0] tout_cnt;
    logic [`JTDR_TOUT_W-1:0] next_tout_cnt;
    logic [2:0] from_tck;
    logic [2:0] from_tck_s;
    logic ext_n_s;
    logic acc_en;
    logic rst_bit;
    logic clr_tgl;

    wire acc_s = from_tck_s[0];
    wire rst_bit_s = from_tck_s[1];
    wire clr_ev = from_tck_s[2] ^ clr_seen;
    wire wr_ev = cpu_wr_i & comm_mapped_o;
    wire rd_ev = cpu_rd_i & comm_mapped_o;
    wire locked = lock_bit_one_i | lock_bit_two_i;
    wire mapped = debug_enable_fuse_i & acc_s; // R8
    wire rst_req = rst_bit_s | ~ext_n_s; // R21
    wire [`JTDR_TOUT_W-1:0] tout_sel = clk_opt_i ? TOUT_SLOW : TOUT_FAST;

    assign from_tck = {clr_tgl, rst_bit, acc_en};

    jtdr_sync #(.W(3), .RST_VAL(3'h0)) u_sync_core (
        .clk_i(clock_i),
        .rst_i(rst_i),
        .d_i(from_tck),
        .q_o(from_tck_s)
    );

    jtdr_sync #(.W(1), .RST_VAL(1'h1)) u_sync_pin (
        .clk_i(clock_i),
        .rst_i(rst_i),
        .d_i(ext_reset_n_i),
        .q_o(ext_n_s)
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            port_en <= 1'b0;
            dbg_ok <= 1'b0;
            tap_hold <= 1'b1;
        end else begin
            port_en <= test_port_enable_fuse_i & ~test_port_disable_bit_i; // R2
            dbg_ok <= debug_enable_fuse_i & ~locked;
            tap_hold <= ~port_en; // R2
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            erased <= 1'b0;
            fuse_prog_grant_o <= 1'b0;
        end else begin
            erased <= erased | chip_erase_i;
            fuse_prog_grant_o <= fuse_prog_req_i & (~locked | erased); // R4
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            comm_byte <= 8'h00;
        end else if (wr_ev) begin
            comm_byte <= cpu_wdata_i; // R5
        end
    end

    // A write in the same cycle as the debugger's clear keeps the flag set.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dirty <= 1'b0;
            clr_seen <= 1'b0;
        end else begin
            dirty <= wr_ev | (dirty & ~clr_ev); // R5 R7
            clr_seen <= from_tck_s[2];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cpu_rdata_o <= 8'h00;
            comm_mapped_o <= 1'b0;
        end else begin
            cpu_rdata_o <= rd_ev ? {dirty, comm_byte[6:0]} : 8'h00; // R6
            comm_mapped_o <= mapped; // R8
        end
    end

    always_comb begin
        next_tout_cnt = tout_cnt;
        if (rst_req) begin
            next_tout_cnt = tout_sel; // R19
        end else if (tout_cnt != '0) begin
            next_tout_cnt = tout_cnt - 1'b1;
        end
    end

    // Port pins float while this output is high.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tout_cnt <= '0;
            core_reset_o <= 1'b1;
            port_enabled_o <= 1'b0;
        end else begin
            tout_cnt <= next_tout_cnt;
            core_reset_o <= rst_req | (tout_cnt != '0); // R10 R18 R19
            port_enabled_o <= port_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test clock side: controller, instruction and data registers.

    logic [2:0] to_tck;
    logic [2:0] to_tck_s;
    jtdr_pkg::jtdr_tap_t st;
    jtdr_pkg::jtdr_tap_t next_st;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] id_sh;
    logic [8:0] dbg_sh;
    logic byp;

    assign to_tck = {dirty, dbg_ok, tap_hold};

    // Runs on the test clock alone, so a stopped core clock is harmless.
    jtdr_sync #(.W(3), .RST_VAL(3'h1)) u_sync_tck ( // R13
        .clk_i(tck_i),
        .rst_i(1'b0),
        .d_i(to_tck),
        .q_o(to_tck_s)
    );

    wire tck_rst = to_tck_s[0];
    wire dbg_ok_t = to_tck_s[1];
    wire dirty_t = to_tck_s[2];
    wire cap_dr = (st == jtdr_pkg::ST_CAPDR);
    wire sh_dr = (st == jtdr_pkg::ST_SHDR);
    wire up_dr = (st == jtdr_pkg::ST_UPDR);
    wire cap_ir = (st == jtdr_pkg::ST_CAPIR);
    wire sh_ir = (st == jtdr_pkg::ST_SHIR);
    wire up_ir = (st == jtdr_pkg::ST_UPIR);

    wire sel_bsr = (ir == `JTDR_IR_EXTEST) | (ir == `JTDR_IR_SAMPLE);
    wire sel_id = (ir == `JTDR_IR_IDCODE);
    wire sel_rst = (ir == `JTDR_IR_DEVRST);
    wire sel_a = dbg_ok_t & (ir == `JTDR_IR_DBG_A); // R1
    wire sel_b = dbg_ok_t & (ir == `JTDR_IR_DBG_B); // R1
    wire sel_dbg = sel_a | sel_b;
    wire sel_byp = ~(sel_bsr | sel_id | sel_rst | sel_dbg); // R28

    wire [31:0] id_val = {VERSION, PART, MFR, 1'b1}; // R15 R16 R17 R27
    wire [8:0] dbg_cap = sel_a ? {dirty_t, comm_byte} : {8'h00, acc_en};
    wire dr_bit = sel_bsr ? bsr_tdo_i : // R22
                  sel_id ? id_sh[0] :
                  sel_rst ? rst_bit :
                  sel_dbg ? dbg_sh[0] : byp; // R28

    always_comb begin
        next_st = st;
        case (st)
            jtdr_pkg::ST_TLR: next_st = tms_i ? jtdr_pkg::ST_TLR : jtdr_pkg::ST_RTI;
            jtdr_pkg::ST_RTI: next_st = tms_i ? jtdr_pkg::ST_SELDR : jtdr_pkg::ST_RTI;
            jtdr_pkg::ST_SELDR: next_st = tms_i ? jtdr_pkg::ST_SELIR : jtdr_pkg::ST_CAPDR;
            jtdr_pkg::ST_CAPDR: next_st = tms_i ? jtdr_pkg::ST_EX1DR : jtdr_pkg::ST_SHDR;
            jtdr_pkg::ST_SHDR: next_st = tms_i ? jtdr_pkg::ST_EX1DR : jtdr_pkg::ST_SHDR;
            jtdr_pkg::ST_EX1DR: next_st = tms_i ? jtdr_pkg::ST_UPDR : jtdr_pkg::ST_PSDR;
            jtdr_pkg::ST_PSDR: next_st = tms_i ? jtdr_pkg::ST_EX2DR : jtdr_pkg::ST_PSDR;
            jtdr_pkg::ST_EX2DR: next_st = tms_i ? jtdr_pkg::ST_UPDR : jtdr_pkg::ST_SHDR;
            jtdr_pkg::ST_UPDR: next_st = tms_i ? jtdr_pkg::ST_SELDR : jtdr_pkg::ST_RTI;
            jtdr_pkg::ST_SELIR: next_st = tms_i ? jtdr_pkg::ST_TLR : jtdr_pkg::ST_CAPIR;
            jtdr_pkg::ST_CAPIR: next_st = tms_i ? jtdr_pkg::ST_EX1IR : jtdr_pkg::ST_SHIR;
            jtdr_pkg::ST_SHIR: next_st = tms_i ? jtdr_pkg::ST_EX1IR : jtdr_pkg::ST_SHIR;
            jtdr_pkg::ST_EX1IR: next_st = tms_i ? jtdr_pkg::ST_UPIR : jtdr_pkg::ST_PSIR;
            jtdr_pkg::ST_PSIR: next_st = tms_i ? jtdr_pkg::ST_EX2IR : jtdr_pkg::ST_PSIR;
            jtdr_pkg::ST_EX2IR: next_st = tms_i ? jtdr_pkg::ST_UPIR : jtdr_pkg::ST_SHIR;
            jtdr_pkg::ST_UPIR: next_st = tms_i ? jtdr_pkg::ST_SELDR : jtdr_pkg::ST_RTI;
            default: next_st = jtdr_pkg::ST_TLR;
        endcase
    end

    // Only tap_hold (block reset or port disabled) resets the controller; device reset does not.
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            st <= jtdr_pkg::ST_TLR;
        end else begin
            st <= next_st; // R25 R26
        end
    end

    always_ff @(posedge tck_i) begin
        if (tck_rst | (st == jtdr_pkg::ST_TLR)) begin
            ir <= `JTDR_IR_IDCODE; // R9
            extest_o <= 1'b0;
            bsr_sel_o <= 1'b0;
        end else if (up_ir) begin
            ir <= ir_sh; // R23
            extest_o <= (ir_sh == `JTDR_IR_EXTEST); // R11
            bsr_sel_o <= (ir_sh == `JTDR_IR_EXTEST) | (ir_sh == `JTDR_IR_SAMPLE);
        end
    end

    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            tap_state_o <= 16'h0001;
        end else begin
            tap_state_o <= next_st; // R22
        end
    end

    jtdr_shreg #(.W(`JTDR_IR_W)) u_ir_sh (
        .clk_i(tck_i),
        .rst_i(tck_rst),
        .capture_i(cap_ir),
        .shift_i(sh_ir),
        .cap_val_i(`JTDR_IR_CAPTURE),
        .sin_i(tdi_i),
        .q_o(ir_sh)
    );

    jtdr_shreg #(.W(`JTDR_ID_W)) u_id_sh (
        .clk_i(tck_i),
        .rst_i(tck_rst),
        .capture_i(cap_dr & sel_id),
        .shift_i(sh_dr & sel_id),
        .cap_val_i(id_val),
        .sin_i(tdi_i),
        .q_o(id_sh)
    );

    jtdr_shreg #(.W(`JTDR_DBG_W)) u_dbg_sh (
        .clk_i(tck_i),
        .rst_i(tck_rst),
        .capture_i(cap_dr & sel_dbg),
        .shift_i(sh_dr & sel_dbg),
        .cap_val_i(dbg_cap),
        .sin_i(tdi_i),
        .q_o(dbg_sh)
    );

    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            byp <= 1'b0;
        end else if (cap_dr & sel_byp) begin
            byp <= 1'b0; // R14
        end else if (sh_dr & sel_byp) begin
            byp <= tdi_i;
        end
    end

    // The reset bit feeds the core directly, with no update stage.
    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            rst_bit <= 1'b0;
        end else if (sh_dr & sel_rst) begin
            rst_bit <= tdi_i; // R20 R21
        end
    end

    always_ff @(posedge tck_i) begin
        if (tck_rst) begin
            acc_en <= 1'b0;
            clr_tgl <= 1'b0;
        end else if (up_dr & sel_b) begin
            acc_en <= dbg_sh[0]; // R8
        end else if (up_dr & sel_a) begin
            clr_tgl <= ~clr_tgl; // R7
        end
    end

    always_ff @(negedge tck_i) begin
        if (tck_rst) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o <= sh_ir ? ir_sh[0] : (sh_dr ? dr_bit : 1'b0); // R24
            tdo_oe_o <= sh_ir | sh_dr; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_idcode_default;
        @(posedge tck_i) disable iff (tck_rst)
        (st == jtdr_pkg::ST_TLR) |=> (ir == `JTDR_IR_IDCODE);
    endproperty
    a_idcode_default: assert property (p_idcode_default) // R9
        else $error("instruction not identification after reset state");

    property p_tms_five;
        @(posedge tck_i) disable iff (tck_rst)
        tms_i [*5] |=> (st == jtdr_pkg::ST_TLR);
    endproperty
    a_tms_five: assert property (p_tms_five) // R26
        else $error("five high TMS did not reach reset state");

    property p_bypass_zero;
        @(posedge tck_i) disable iff (tck_rst)
        (cap_dr && sel_byp) |=> (byp == 1'b0);
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) // R14
        else $error("bypass not zero after capture");

    property p_id_capture;
        @(posedge tck_i) disable iff (tck_rst)
        (cap_dr && sel_id) |=> (id_sh[0] == 1'b1) && (id_sh[31:28] == VERSION)
            && (id_sh[27:12] == PART) && (id_sh[11:1] == MFR);
    endproperty
    a_id_capture: assert property (p_id_capture) // R27
        else $error("identification capture wrong");

    property p_reset_bit;
        @(posedge tck_i) disable iff (tck_rst)
        (sh_dr && sel_rst) |=> (rst_bit == $past(tdi_i));
    endproperty
    a_reset_bit: assert property (p_reset_bit) // R20
        else $error("reset bit did not follow shifted data");

    property p_dirty_set;
        @(posedge clock_i) disable iff (rst_i)
        wr_ev |=> dirty && (comm_byte == $past(cpu_wdata_i));
    endproperty
    a_dirty_set: assert property (p_dirty_set) // R5
        else $error("write did not store byte and set dirty");

    property p_read_msb;
        @(posedge clock_i) disable iff (rst_i)
        rd_ev |=> (cpu_rdata_o == {$past(dirty), $past(comm_byte[6:0])});
    endproperty
    a_read_msb: assert property (p_read_msb) // R6
        else $error("read data not dirty plus seven bits");

    property p_fuse_refuse;
        @(posedge clock_i) disable iff (rst_i)
        (locked && !erased) |=> !fuse_prog_grant_o;
    endproperty
    a_fuse_refuse: assert property (p_fuse_refuse) // R4
        else $error("debug fuse granted on locked part");

    property p_reset_hold;
        @(posedge clock_i) disable iff (rst_i)
        rst_bit_s |=> core_reset_o [*2];
    endproperty
    a_reset_hold: assert property (p_reset_hold) // R18
        else $error("device left reset while reset bit set");

    property p_port_off;
        @(posedge clock_i) disable iff (rst_i)
        (!test_port_enable_fuse_i || test_port_disable_bit_i)
            |=> ##1 (tap_hold && !port_enabled_o);
    endproperty
    a_port_off: assert property (p_port_off) // R2
        else $error("test port enabled against fuse or disable bit");

endmodule
`default_nettype wire
